// file: design/ocs_iodec.sv
// registered decode and qualification of host i/o operations
`timescale 1ns/100ps
`include "ocs_map.svh"
module ocs_iodec (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // operation in
   input wire logic io_valid_in,
   input wire ocs_pkg::ocs_io_t io_in,
   // adapter context
   input wire logic [3:0] own_addr_in,
   input wire logic selected_in,
   input wire logic busy_in,
   // decoded operation out
   output ocs_pkg::ocs_cmd_t cmd_out
);

   // ----------------------------------------------------------------
   // decode function
   // ----------------------------------------------------------------
   function automatic ocs_pkg::ocs_cmd_t decode(
      input ocs_pkg::ocs_io_t op,
      input logic [3:0] own,
      input logic sel,
      input logic busy
   );
      ocs_pkg::ocs_cmd_t c;
      logic programmed_transfer_mode;
      c = '0;
      programmed_transfer_mode = sel && !busy;
      c.data = op.data;
      // control is reachable while deselected, so reset/select work
      c.ctrl = op.is_out && op.code == `OCS_OP_CTRL;
      c.load_cnt = programmed_transfer_mode && op.is_out && op.code == `OCS_OP_COUNT;
      c.load_addr = programmed_transfer_mode && op.is_out && op.code[7:4] == `OCS_OP_ADDR_HI
         && op.code[3:0] == own;
      c.clr_a = programmed_transfer_mode && op.is_out && op.code == `OCS_OP_BUF_A;
      c.clr_b = programmed_transfer_mode && op.is_out && op.code == `OCS_OP_BUF_B;
      c.advance = programmed_transfer_mode && op.is_out && op.code == `OCS_OP_PTR;
      c.start = programmed_transfer_mode && op.is_out && op.code == `OCS_OP_START;
      c.rd_word = programmed_transfer_mode && !op.is_out && op.code == `OCS_OP_BUF_A;
      c.rd_stat = sel && !op.is_out && op.code == `OCS_OP_BUF_B;
      return c;
   endfunction : decode

   // one-cycle registered command
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cmd_out <= '0;
      end else if (io_valid_in) begin
         cmd_out <= decode(io_in, own_addr_in, selected_in, busy_in);
      end else begin
         cmd_out <= '0;
      end
   end

endmodule : ocs_iodec

// file: design/ocs_skid.sv
// two-entry buffer between storage fetch data and buffer fill
`timescale 1ns/100ps
module ocs_skid #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic clear_in,
   // filling side
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   // draining side
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_chk
      $error("ocs_skid: DEPTH must be a power of two of at least 2");
   end

   logic [W-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ff;
   logic [PW-1:0] rd_ff;
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic push;
   logic pop;

   // handshakes; ready is a flop so it never loops back combinationally
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_valid_out = (cnt_ff != '0);
   assign out_data_out = mem_ff[rd_ff];

   // occupancy next value
   always_comb begin
      nxt_cnt = cnt_ff;
      if (clear_in) begin
         nxt_cnt = '0;
      end else if (push && !pop) begin
         nxt_cnt = cnt_ff + CW'(1);
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - CW'(1);
      end
   end

   // pointers, count and ready
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         in_ready_out <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt;
         in_ready_out <= (nxt_cnt != FULL);
         if (clear_in) begin
            wr_ff <= '0;
            rd_ff <= '0;
         end else begin
            if (push) begin
               wr_ff <= wr_ff + PW'(1);
            end
            if (pop) begin
               rd_ff <= rd_ff + PW'(1);
            end
         end
      end
   end

   // entry storage
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data_in;
      end
   end

   // a stall downstream never drops a word
   a_skid_noover: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cnt_ff == FULL |-> !in_ready_out)
      else $error("skid accepts while full");

endmodule : ocs_skid

// file: design/ocs_top.sv
// outbound cycle-steal buffer fill: count, address, fetch, readback
`timescale 1ns/100ps
`include "ocs_map.svh"
module ocs_top #(
   parameter int AW = 16
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // adapter address strap
   input wire logic [3:0] ca_addr_in,
   // host i/o operations
   input wire logic io_valid_in,
   input wire ocs_pkg::ocs_io_t io_in,
   output logic io_rvalid_out,
   output logic [15:0] io_rdata_out,
   // storage fetch requests
   output logic mem_req_out,
   output logic [AW-1:0] mem_addr_out,
   input wire logic mem_gnt_in,
   // storage fetch data
   input wire logic mem_rvalid_in,
   input wire logic [7:0] mem_rdata_in,
   output logic mem_rready_out,
   // status
   output logic busy_out,
   output logic done_out
);
   localparam int NB = 2 * `OCS_BUF_BYTES;

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (AW < 2 || AW > 32) begin : g_chk
      $error("ocs_top: AW must lie between 2 and 32");
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [3:0] addr_meta_ff;
   logic [3:0] own_addr_ff;
   ocs_pkg::ocs_cmd_t cmd;
   ocs_pkg::ocs_state_t state_ff;
   logic selected_ff;
   logic [4:0] count_ff;
   logic [AW-1:0] addr_ff;
   logic [4:0] issued_ff;
   logic [4:0] filled_ff;
   logic [2:0] ptr_ff;
   logic [NB-1:0][7:0] buf_ff;
   logic sk_valid;
   logic [7:0] sk_data;
   logic sk_ready;
   logic sk_clear;
   logic drain;
   logic accept;
   logic do_reset;
   logic go;
   logic [4:0] nxt_count;

   // ----------------------------------------------------------------
   // strap synchroniser
   // ----------------------------------------------------------------
   // two stages; only the second one is read
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         addr_meta_ff <= 4'h0;
         own_addr_ff <= 4'h0;
      end else begin
         addr_meta_ff <= ca_addr_in;
         own_addr_ff <= addr_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // operation decode
   // ----------------------------------------------------------------
   ocs_iodec u_dec (
      .clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .io_valid_in(io_valid_in),
      .io_in(io_in),
      .own_addr_in(own_addr_ff),
      .selected_in(selected_ff),
      .busy_in(busy_out),
      .cmd_out(cmd)
   );

   assign do_reset = cmd.ctrl && cmd.data[`OCS_CTRL_RESET_BIT];
   assign go = cmd.start && count_ff != 5'h00;
   assign accept = mem_rvalid_in && mem_rready_out;
   // host access takes the buffer port, so the fill stalls that cycle;
   // a reset op freezes the buffers in its own cycle as well
   assign drain = sk_valid && state_ff != ocs_pkg::ST_IDLE
      && filled_ff < count_ff && !io_valid_in && !do_reset;
   assign sk_clear = do_reset || go;

   // clamp oversize counts to the largest accepted one
   assign nxt_count = (cmd.data[7:0] > 8'(`OCS_MAX_COUNT)) ?
      `OCS_MAX_COUNT : cmd.data[`OCS_COUNT_MSB:0];

   // ----------------------------------------------------------------
   // selection and setup registers
   // ----------------------------------------------------------------
   // reset deselects, a plain control op selects; buffers untouched
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         selected_ff <= 1'b0;
      end else if (cmd.ctrl) begin
         selected_ff <= !cmd.data[`OCS_CTRL_RESET_BIT];
      end
   end

   // byte counter and start address
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_ff <= `OCS_RST_COUNT;
         addr_ff <= AW'(`OCS_RST_ADDR);
      end else begin
         if (do_reset) begin
            count_ff <= `OCS_RST_COUNT;
         end else if (cmd.load_cnt) begin
            count_ff <= nxt_count;
         end
         if (cmd.load_addr) begin
            addr_ff <= AW'(cmd.data);
         end
      end
   end

   // ----------------------------------------------------------------
   // autonomous fetch sequencer
   // ----------------------------------------------------------------
   // one request outstanding at a time; bytes in storage order
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_ff <= ocs_pkg::ST_IDLE;
         mem_req_out <= 1'b0;
         mem_addr_out <= '0;
         issued_ff <= 5'h00;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (do_reset) begin
            state_ff <= ocs_pkg::ST_IDLE;
            mem_req_out <= 1'b0;
            busy_out <= 1'b0;
         end else begin
            unique case (state_ff)
               ocs_pkg::ST_IDLE: begin
                  if (go) begin
                     state_ff <= ocs_pkg::ST_REQ;
                     mem_req_out <= 1'b1;
                     mem_addr_out <= addr_ff;
                     issued_ff <= 5'h00;
                     busy_out <= 1'b1;
                  end
               end
               ocs_pkg::ST_REQ: begin
                  if (mem_gnt_in) begin
                     mem_req_out <= 1'b0;
                     issued_ff <= issued_ff + 5'h01;
                     state_ff <= ocs_pkg::ST_WAIT;
                  end
               end
               ocs_pkg::ST_WAIT: begin
                  if (accept) begin
                     if (issued_ff == count_ff) begin
                        state_ff <= ocs_pkg::ST_FLUSH;
                     end else begin
                        state_ff <= ocs_pkg::ST_REQ;
                        mem_req_out <= 1'b1;
                        mem_addr_out <= mem_addr_out + AW'(1);
                     end
                  end
               end
               ocs_pkg::ST_FLUSH: begin
                  if (filled_ff == count_ff) begin
                     state_ff <= ocs_pkg::ST_IDLE;
                     busy_out <= 1'b0;
                     done_out <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // fetch data buffer
   // ----------------------------------------------------------------
   ocs_skid #(
      .W(8),
      .DEPTH(2)
   ) u_skid (
      .clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .clear_in(sk_clear),
      .in_valid_in(mem_rvalid_in),
      .in_data_in(mem_rdata_in),
      .in_ready_out(sk_ready),
      .out_valid_out(sk_valid),
      .out_data_out(sk_data),
      .out_ready_in(drain)
   );
   assign mem_rready_out = sk_ready;

   // ----------------------------------------------------------------
   // buffer fill position and readback pointer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         filled_ff <= 5'h00;
      end else if (go) begin
         filled_ff <= 5'h00;
      end else if (drain) begin
         filled_ff <= filled_ff + 5'h01;
      end
   end

   // pointer walks words A0..A3 then B0..B3
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ptr_ff <= `OCS_RST_PTR;
      end else if (cmd.ctrl) begin
         ptr_ff <= `OCS_RST_PTR;
      end else if (cmd.advance) begin
         ptr_ff <= ptr_ff + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // buffer bytes A0..A7 then B0..B7
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NB; i++) begin : g_byte
      localparam logic IS_B = (i >= `OCS_BUF_BYTES);
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            buf_ff[i] <= `OCS_RST_BYTE;
         end else if ((cmd.clr_a && !IS_B) || (cmd.clr_b && IS_B)) begin
            buf_ff[i] <= `OCS_RST_BYTE;
         end else if (drain && filled_ff[3:0] == 4'(i)) begin
            buf_ff[i] <= sk_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // readback answers
   // ----------------------------------------------------------------
   // word: lower byte high; status: busy, pointer, fill position
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         io_rvalid_out <= 1'b0;
         io_rdata_out <= `OCS_RST_WORD;
      end else begin
         io_rvalid_out <= cmd.rd_word || cmd.rd_stat;
         if (cmd.rd_word) begin
            io_rdata_out <= {buf_ff[{ptr_ff, 1'b0}],
               buf_ff[{ptr_ff, 1'b1}]};
         end else if (cmd.rd_stat) begin
            io_rdata_out <= {busy_out, 4'h0, ptr_ff, 3'h0, filled_ff};
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_start;
      state_ff == ocs_pkg::ST_IDLE && go && !do_reset;
   endsequence

   sequence s_first_req;
      mem_req_out && busy_out && mem_addr_out == $past(addr_ff);
   endsequence

   a_start_fetch: assert property (s_start |=> s_first_req)
      else $error("start did not raise a request at the start address");

   a_count_load: assert property (cmd.load_cnt && !do_reset |=>
      count_ff == $past(nxt_count) && count_ff <= `OCS_MAX_COUNT)
      else $error("byte counter not loaded");

   a_addr_load: assert property (cmd.load_addr |=>
      addr_ff == $past(AW'(cmd.data)))
      else $error("address register not loaded");

   a_clear_zero: assert property (cmd.clr_a |=>
      buf_ff[7:0] == '0)
      else $error("buffer A not zeroed");

   a_reset_keeps: assert property (do_reset |=>
      state_ff == ocs_pkg::ST_IDLE && !selected_ff && $stable(buf_ff))
      else $error("reset lost buffer data or left fetch running");

   a_word_order: assert property (cmd.rd_word |=> io_rvalid_out
      && io_rdata_out[15:8] == $past(buf_ff[{ptr_ff, 1'b0}]))
      else $error("readback word byte order wrong");

   a_fill_bound: assert property (busy_out |->
      filled_ff <= count_ff && issued_ff <= count_ff)
      else $error("fetch ran past the byte count");

   a_ninth_b: assert property (drain && filled_ff == 5'h08 |=>
      buf_ff[8] == $past(sk_data) && buf_ff[7] == $past(buf_ff[7]))
      else $error("ninth byte not placed in buffer B byte 0");

   a_first_byte: assert property (drain && filled_ff == 5'h00 |=>
      buf_ff[0] == $past(sk_data) && $stable(buf_ff[NB-1:1]))
      else $error("first byte misplaced");

   a_last_done: assert property (state_ff == ocs_pkg::ST_FLUSH
      && filled_ff == count_ff && !do_reset |=> done_out && !busy_out)
      else $error("fetch did not finish after the last byte");

endmodule : ocs_top

// file: inc/ocs_map.svh
// constants for the outbound cycle-steal buffer fill block
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH

// ----------------------------------------------------------------
// i/o operation codes
// ----------------------------------------------------------------
`define OCS_OP_COUNT 8'h6c
`define OCS_OP_ADDR_HI 4'h3
`define OCS_OP_BUF_A 8'h64
`define OCS_OP_BUF_B 8'h65
`define OCS_OP_PTR 8'h66
`define OCS_OP_START 8'h62
`define OCS_OP_CTRL 8'h67

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OCS_CTRL_RESET_BIT 0
`define OCS_COUNT_MSB 4

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define OCS_MAX_COUNT 5'h10
`define OCS_BUF_BYTES 8
`define OCS_RST_COUNT 5'h00
`define OCS_RST_ADDR 16'h0000
`define OCS_RST_BYTE 8'h00
`define OCS_RST_PTR 3'h0
`define OCS_RST_WORD 16'h0000

`endif

// file: inc/ocs_pkg.sv
// types shared by the outbound cycle-steal buffer fill block
package ocs_pkg;

   // one i/o operation from the host
   typedef struct packed {
      logic is_out;
      logic [7:0] code;
      logic [15:0] data;
   } ocs_io_t;

   // decoded and qualified operation
   typedef struct packed {
      logic load_cnt;
      logic load_addr;
      logic clr_a;
      logic clr_b;
      logic advance;
      logic start;
      logic ctrl;
      logic rd_word;
      logic rd_stat;
      logic [15:0] data;
   } ocs_cmd_t;

   // autonomous fetch sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_REQ,
      ST_WAIT,
      ST_FLUSH
   } ocs_state_t;

endpackage : ocs_pkg

// file: verif/ocs_mem_model.sv
// storage model answering byte fetch requests of the buffer fill block
`timescale 1ns/100ps
module ocs_mem_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // pacing from the bench
   input wire logic stall_in,
   // fetch requests
   input wire logic mem_req_in,
   input wire logic [15:0] mem_addr_in,
   output logic mem_gnt_out,
   // fetch data
   output logic mem_rvalid_out,
   output logic [7:0] mem_rdata_out,
   input wire logic mem_rready_in
);
   logic pend_ff;
   logic [15:0] addr_ff;

   // storage content: never zero, so cleared positions stand out
   function automatic logic [7:0] byte_at(input logic [15:0] a);
      return {1'b1, a[6:0] ^ a[14:8]};
   endfunction : byte_at

   // ------------------------------------------------------------
   // grant one request at a time, then return its byte
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mem_gnt_out <= 1'b0;
         pend_ff <= 1'b0;
         addr_ff <= 16'h0000;
         mem_rvalid_out <= 1'b0;
         mem_rdata_out <= 8'ha5;
      end else begin
         if (mem_gnt_out && mem_req_in) begin
            mem_gnt_out <= 1'b0;
            pend_ff <= 1'b1;
            addr_ff <= mem_addr_in;
         end else if (mem_gnt_out) begin
            mem_gnt_out <= 1'b0;
         end else if (mem_req_in && !pend_ff && !mem_rvalid_out &&
                      !stall_in) begin
            mem_gnt_out <= 1'b1;
         end
         // data held until taken, then inverted so stale bytes show
         if (pend_ff && !stall_in) begin
            mem_rvalid_out <= 1'b1;
            mem_rdata_out <= byte_at(addr_ff);
            pend_ff <= 1'b0;
         end
         if (mem_rvalid_out && mem_rready_in) begin
            mem_rvalid_out <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
         end
      end
   end
endmodule : ocs_mem_model

// file: verif/ocs_top_tb.sv
// self-checking bench for the outbound cycle-steal buffer fill block
`timescale 1ns/100ps
`include "ocs_map.svh"
module ocs_top_tb;
   logic ref_clk_in;
   logic rstn_in;
   logic [3:0] strap;
   logic io_valid;
   ocs_pkg::ocs_io_t io;
   logic io_rvalid;
   logic [15:0] io_rdata;
   logic mem_req;
   logic [15:0] mem_addr;
   logic mem_gnt;
   logic mem_rvalid;
   logic [7:0] mem_rdata;
   logic mem_rready;
   logic busy;
   logic done;
   logic stall;
   logic stall_en;
   logic [31:0] rnd;
   logic [31:0] srnd;
   integer seed = 32'he91d8d59;
   int error_cnt = 0;
   int checks = 0;
   int n;
   logic [15:0] exp_q[$];

   // ------------------------------------------------------------
   // clock, design and storage
   // ------------------------------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end

   ocs_top dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .ca_addr_in(strap), .io_valid_in(io_valid), .io_in(io),
      .io_rvalid_out(io_rvalid), .io_rdata_out(io_rdata),
      .mem_req_out(mem_req), .mem_addr_out(mem_addr),
      .mem_gnt_in(mem_gnt), .mem_rvalid_in(mem_rvalid),
      .mem_rdata_in(mem_rdata), .mem_rready_out(mem_rready),
      .busy_out(busy), .done_out(done));

   ocs_mem_model mem (.clk_in(ref_clk_in), .rstn_in(rstn_in),
      .stall_in(stall), .mem_req_in(mem_req), .mem_addr_in(mem_addr),
      .mem_gnt_out(mem_gnt), .mem_rvalid_out(mem_rvalid),
      .mem_rdata_out(mem_rdata), .mem_rready_in(mem_rready));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_byte(input logic [15:0] a);
      return {1'b1, a[6:0] ^ a[14:8]};
   endfunction : exp_byte

   task automatic mismatch(input string m);
      error_cnt++;
      $display("MISMATCH at %0t: %s", $time, m);
   endtask : mismatch

   task automatic end_sim;
      if (exp_q.size() != 0) mismatch("answers missing");
      $display("errors %0d, checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   // one operation per cycle, valid left up for back-to-back use
   task automatic io_op(input logic o, input logic [7:0] c,
                        input logic [15:0] d);
      io_valid = 1'b1;
      io = {o, c, d};
      @(posedge ref_clk_in);
      #1;
   endtask : io_op

   task automatic io_idle;
      io_valid = 1'b0;
      @(posedge ref_clk_in);
      #1;
   endtask : io_idle

   // full transfer: set up, fetch, reset, reselect, read back
   task automatic run(input logic [7:0] cnt, input logic [15:0] s);
      int k;
      int eff;
      logic [7:0] b[16];
      eff = (cnt > 8'd16) ? 16 : int'(cnt);
      for (k = 0; k < 16; k++) begin
         b[k] = (k < eff) ? exp_byte(s + 16'(k)) : 8'h00;
      end
      io_op(1'b1, `OCS_OP_CTRL, 16'h0001);
      io_op(1'b1, `OCS_OP_CTRL, 16'h0000);
      io_idle(); // selection settles before the next op is decoded
      io_op(1'b1, `OCS_OP_COUNT, {8'h00, cnt});
      io_op(1'b1, {`OCS_OP_ADDR_HI, strap}, s);
      io_op(1'b1, {`OCS_OP_ADDR_HI, strap ^ 4'h1}, ~s);
      io_op(1'b1, `OCS_OP_BUF_A, 16'hffff);
      io_op(1'b1, `OCS_OP_BUF_B, 16'hffff);
      io_op(1'b1, `OCS_OP_PTR, 16'h0000);
      io_op(1'b1, `OCS_OP_START, 16'h0000);
      io_idle();
      for (k = 0; k < 2000 && done !== 1'b1; k++) begin
         @(posedge ref_clk_in);
         #1;
      end
      checks++;
      if (done !== 1'b1) mismatch("fetch did not finish");
      exp_q.push_back({1'b0, 4'h0, 3'h1, 3'h0, 5'(eff)});
      io_op(1'b0, `OCS_OP_BUF_B, 16'h0000);
      io_op(1'b1, `OCS_OP_CTRL, 16'h0001);
      io_idle(); // deselect settles, so the next read must be refused
      io_op(1'b0, `OCS_OP_BUF_A, 16'h0000);
      io_op(1'b1, `OCS_OP_CTRL, 16'h0000);
      io_idle(); // reselect settles before the first word read
      for (k = 0; k < 8; k++) begin
         exp_q.push_back({b[2*k], b[2*k+1]});
         io_op(1'b0, `OCS_OP_BUF_A, 16'h0000);
         io_op(1'b1, `OCS_OP_PTR, 16'h0000);
      end
      io_idle();
      repeat (3) io_idle();
   endtask : run

   // ------------------------------------------------------------
   // answer checker: oldest expected word against each answer
   // ------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (rstn_in === 1'b1 && io_rvalid === 1'b1) begin
         checks++;
         if (exp_q.size() == 0) begin
            mismatch("answer without request");
         end else if (io_rdata !== exp_q.pop_front()) begin
            mismatch("readback word differs");
         end
      end
   end

   // random storage stalls once enabled
   always @(posedge ref_clk_in) begin
      #1;
      srnd = $random(seed);
      stall = stall_en & srnd[0];
   end

   // watchdog
   initial begin
      #400000;
      mismatch("timeout");
      end_sim();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rstn_in = 1'b0;
      io_valid = 1'b0;
      io = '0;
      stall_en = 1'b0;
      rnd = $random(seed);
      strap = rnd[3:0];
      repeat (5) @(posedge ref_clk_in);
      #1;
      rstn_in = 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      run(8'd16, 16'h0100);
      run(8'd16, 16'h0203);
      run(8'd1, 16'h0100);
      run(8'd9, 16'h1100);
      run(8'd20, 16'h0a0b);
      stall_en = 1'b1;
      for (n = 2; n <= 15; n++) begin
         rnd = $random(seed);
         run(8'(n), rnd[15:0]);
      end
      // a start with count zero must not fetch
      io_op(1'b1, `OCS_OP_CTRL, 16'h0000);
      io_idle();
      io_op(1'b1, `OCS_OP_COUNT, 16'h0000);
      io_op(1'b1, `OCS_OP_START, 16'h0000);
      io_idle();
      repeat (3) io_idle();
      checks++;
      if (busy !== 1'b0 || mem_req !== 1'b0) begin
         mismatch("fetch ran with count zero");
      end
      end_sim();
   end
endmodule : ocs_top_tb
